// ### design/bsc_pkg.sv
// Constants shared by the sine-PWM brushless controller
package bsc_pkg;

	// ************************************************
	// Register map
	// ************************************************
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_STATUS     = 8'h04;
	localparam int          CTRL_DIR_BIT    = 0;
	localparam int          CTRL_POL_BIT    = 1;
	localparam int          CTRL_DEAD_BIT   = 2;
	localparam int          CTRL_ADV_LSB    = 3;
	localparam int          CTRL_AMP_LSB    = 8;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0004;
	localparam logic [2:0]  PHASE_OFF_RESET = 3'h7; // Idle gate level for the active-low reset polarity
	localparam int          STAT_BACK_BIT   = 3;
	localparam int          STAT_BLOCK_BIT  = 4;
	localparam int          STAT_PULSE_BIT  = 5;
	localparam int          STAT_OVC_BIT    = 6;
	localparam int          STAT_HALT_BIT   = 7;

	// ************************************************
	// Timing
	// ************************************************
	localparam int          CLK_MHZ         = 200;
	localparam int          CARRIER_PERIOD  = 252;
	localparam logic [6:0]  CARRIER_TOP     = 7'(CARRIER_PERIOD / 2 - 1);
	localparam int          DEAD_LONG_NS    = 3800;
	localparam int          DEAD_SHORT_NS   = 2600;
	localparam logic [9:0]  DEAD_LONG_CYC   = 10'((DEAD_LONG_NS * CLK_MHZ + 999) / 1000);
	localparam logic [9:0]  DEAD_SHORT_CYC  = 10'((DEAD_SHORT_NS * CLK_MHZ + 999) / 1000);

	// ************************************************
	// Electrical angle, 192 units per turn (1.875 deg each)
	// ************************************************
	localparam int          ANGLE_TURN      = 192;
	localparam int          SECTOR_SPAN     = 32;
	localparam int          QUARTER_TURN    = 48;
	localparam int          PHASE_SHIFT     = 64;
	localparam logic [6:0]  MOD_MID         = 7'd63;

	typedef enum logic [1:0] {
		BSC_IDLE  = 2'b00,
		BSC_DEAD  = 2'b01,
		BSC_DRIVE = 2'b11
	} bsc_dead_state_t;

endpackage

// ### design/bsc_dead_band.sv
// Dead-time inserter for one complementary phase pair
`timescale 1ns/1ps
module bsc_dead_band
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       wantUpper,
	input  wire logic       block,
	input  wire logic [9:0] deadCycles,
	output logic            upperOn,
	output logic            lowerOn
);

	bsc_pkg::bsc_dead_state_t stateQ;
	logic [9:0]               countQ;
	logic                     sideQ;

	// ************************************************
	// Break-before-make sequencing
	// ************************************************
	// dead gap insertion
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stateQ  <= bsc_pkg::BSC_IDLE;
			countQ  <= 10'h000;
			sideQ   <= 1'b0;
			upperOn <= 1'b0;
			lowerOn <= 1'b0;
		end
		else if (block)
		begin
			// Restart with a full gap so release never shoots through
			stateQ  <= bsc_pkg::BSC_IDLE;
			countQ  <= 10'h000;
			upperOn <= 1'b0;
			lowerOn <= 1'b0;
		end
		else
		begin
			unique case (stateQ)
				bsc_pkg::BSC_IDLE:
				begin
					stateQ <= bsc_pkg::BSC_DEAD;
					countQ <= deadCycles;
					sideQ  <= wantUpper;
				end
				bsc_pkg::BSC_DEAD:
				begin
					if (countQ <= 10'h001)
					begin
						stateQ  <= bsc_pkg::BSC_DRIVE;
						upperOn <= sideQ;
						lowerOn <= ~sideQ;
					end
					else
						countQ <= countQ - 10'h001;
				end
				bsc_pkg::BSC_DRIVE:
				begin
					if (wantUpper != sideQ)
					begin
						stateQ  <= bsc_pkg::BSC_DEAD;
						countQ  <= deadCycles;
						sideQ   <= wantUpper;
						upperOn <= 1'b0;
						lowerOn <= 1'b0;
					end
				end
				default:
					stateQ <= bsc_pkg::BSC_IDLE;
			endcase
		end
	end

endmodule // bsc_dead_band

// ### design/bsc_sine_pwm.sv
// Sine-PWM brushless controller top with APB registers
`timescale 1ns/1ps
module bsc_sine_pwm
#(
	parameter int TIMER_W = 20
)
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rotorPosition1,
	input  wire logic        rotorPosition2,
	input  wire logic        rotorPosition3,
	input  wire logic        haltInput_n,
	input  wire logic        overcurrentSense,
	output logic      [2:0]  phaseUpper,
	output logic      [2:0]  phaseLower,
	output logic             speedPulseOutput,
	output logic             backwardSpinFlag
);

	// ************************************************
	// Helper functions
	// ************************************************
	// Hall code to sector 0..5, forward order; 7 marks an illegal code
	function automatic logic [2:0] hallSector(input logic [2:0] h);
		unique case (h)
			3'b101:  hallSector = 3'h0;
			3'b100:  hallSector = 3'h1;
			3'b110:  hallSector = 3'h2;
			3'b010:  hallSector = 3'h3;
			3'b011:  hallSector = 3'h4;
			3'b001:  hallSector = 3'h5;
			default: hallSector = 3'h7;
		endcase
	endfunction

	// Fold any small signed sum into one turn
	function automatic logic [7:0] wrapAngle(input int a);
		int r;
		r = (a + 2 * bsc_pkg::ANGLE_TURN) % bsc_pkg::ANGLE_TURN;
		wrapAngle = 8'(r);
	endfunction

	// Parabolic sine: 63 +/- scaled half-wave, range 1..125
	function automatic logic [6:0] sineLevel(input logic [7:0] ang, input logic [7:0] amp);
		logic [7:0]  x;
		logic [11:0] s;
		logic [22:0] p;
		logic [6:0]  m;
		x = (ang >= 8'd96) ? ang - 8'd96 : ang;
		s = 12'(x * (8'd96 - x));
		p = 23'(s * amp * 7);
		m = 7'(p >> 16);
		sineLevel = (ang >= 8'd96) ? bsc_pkg::MOD_MID - m : bsc_pkg::MOD_MID + m;
	endfunction

	// ************************************************
	// Input synchronisers
	// ************************************************
	logic [4:0] syncAQ;
	logic [4:0] syncBQ;

	// Pins are asynchronous to clk, two flops each
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			syncAQ <= 5'h00;
			syncBQ <= 5'h00;
		end
		else
		begin
			syncAQ <= {overcurrentSense, haltInput_n, rotorPosition1, rotorPosition2, rotorPosition3};
			syncBQ <= syncAQ;
		end
	end

	logic [2:0] hall;
	logic       haltOk;
	logic       overCurrent;
	assign hall        = syncBQ[2:0];
	assign haltOk      = syncBQ[3];
	assign overCurrent = syncBQ[4];

	// ************************************************
	// APB register file
	// ************************************************
	logic [31:0] ctrlQ;
	logic        setupPhase;
	logic        addrOk;
	logic [31:0] statusWord;
	logic [2:0]  sectorQ;
	logic        blockQ;
	logic        backQ;

	assign setupPhase = psel & ~penable;
	assign addrOk     = (paddr == bsc_pkg::ADDR_CTRL) | (paddr == bsc_pkg::ADDR_STATUS);
	assign statusWord = {24'h000000, ~haltOk, overCurrent, speedPulseOutput, blockQ, backQ, sectorQ};

	// Control writes land on the access edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrlQ <= bsc_pkg::CTRL_RESET;
		else if (psel && penable && pready && pwrite && paddr == bsc_pkg::ADDR_CTRL)
			ctrlQ <= pwdata;
	end

	// Answer in the first access cycle; read data captured at setup
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setupPhase;
			pslverr <= setupPhase & ~addrOk;
			if (setupPhase && !pwrite)
				prdata <= (paddr == bsc_pkg::ADDR_CTRL) ? ctrlQ
				        : (paddr == bsc_pkg::ADDR_STATUS) ? statusWord : 32'h0000_0000;
		end
	end

	logic       dirRev;
	logic       polHigh;
	logic       deadShort;
	logic [4:0] advance;
	logic [7:0] amplitude;
	logic [9:0] deadCycles;
	assign dirRev    = ctrlQ[bsc_pkg::CTRL_DIR_BIT];
	assign polHigh   = ctrlQ[bsc_pkg::CTRL_POL_BIT];
	assign deadShort = ctrlQ[bsc_pkg::CTRL_DEAD_BIT];
	assign advance   = ctrlQ[bsc_pkg::CTRL_ADV_LSB +: 5];
	assign amplitude = ctrlQ[bsc_pkg::CTRL_AMP_LSB +: 8];
	assign deadCycles = deadShort ? bsc_pkg::DEAD_SHORT_CYC : bsc_pkg::DEAD_LONG_CYC;

	// ************************************************
	// Triangular carrier
	// ************************************************
	logic [6:0] carrierQ;
	logic       carrierDownQ;

	// up 126 steps, down 126 steps
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			carrierQ     <= 7'h00;
			carrierDownQ <= 1'b0;
		end
		else if (!carrierDownQ)
		begin
			if (carrierQ == bsc_pkg::CARRIER_TOP)
				carrierDownQ <= 1'b1;
			else
				carrierQ <= carrierQ + 7'h01;
		end
		else
		begin
			if (carrierQ == 7'h00)
				carrierDownQ <= 1'b0;
			else
				carrierQ <= carrierQ - 7'h01;
		end
	end

	// ************************************************
	// Rotor tracking
	// ************************************************
	logic [2:0]         sectorNow;
	logic               hallBad;
	logic               hallEdge;
	logic               stepFwd;
	logic               stepRev;
	logic               measRevQ;
	logic [TIMER_W-1:0] sectorTimeQ;
	logic [TIMER_W-1:0] lastPeriodQ;
	logic [TIMER_W-1:0] subCountQ;
	logic [4:0]         fineQ;

	assign sectorNow = hallSector(hall);
	assign hallBad   = (hall == 3'b000) | (hall == 3'b111);
	assign hallEdge  = ~hallBad & (sectorNow != sectorQ);
	assign stepFwd   = sectorNow == ((sectorQ == 3'h5) ? 3'h0 : sectorQ + 3'h1);
	assign stepRev   = sectorNow == ((sectorQ == 3'h0) ? 3'h5 : sectorQ - 3'h1);

	// Sector capture and measured direction
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sectorQ  <= 3'h0;
			measRevQ <= 1'b0;
		end
		else if (haltOk && hallEdge)
		begin
			sectorQ <= sectorNow;
			if (stepFwd)
				measRevQ <= 1'b0;
			else if (stepRev)
				measRevQ <= 1'b1;
		end
	end

	// Sector duration, saturating so a stalled rotor never wraps
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sectorTimeQ <= '0;
			lastPeriodQ <= '1;
		end
		else if (!haltOk)
			sectorTimeQ <= '0;
		else if (hallEdge)
		begin
			lastPeriodQ <= sectorTimeQ;
			sectorTimeQ <= '0;
		end
		else if (sectorTimeQ != '1)
			sectorTimeQ <= sectorTimeQ + 1'b1;
	end

	// Interpolate 32 fine steps across one sector; stops at the last
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			fineQ     <= 5'h00;
			subCountQ <= '0;
		end
		else if (!haltOk || hallEdge)
		begin
			fineQ     <= 5'h00;
			subCountQ <= '0;
		end
		else if (subCountQ >= (lastPeriodQ >> 5))
		begin
			subCountQ <= '0;
			if (fineQ != 5'h1f)
				fineQ <= fineQ + 5'h01;
		end
		else
			subCountQ <= subCountQ + 1'b1;
	end

	// ************************************************
	// Drive angle and modulation
	// ************************************************
	int         rotorAngle;
	logic [7:0] driveAngle;

	// field leads in the commanded direction
	// lead of a quarter turn (48 units) plus 0..31 units of 1.875 deg
	always_comb
	begin
		if (measRevQ)
			rotorAngle = int'(sectorQ) * bsc_pkg::SECTOR_SPAN + bsc_pkg::SECTOR_SPAN - 1 - int'(fineQ);
		else
			rotorAngle = int'(sectorQ) * bsc_pkg::SECTOR_SPAN + int'(fineQ);
		if (dirRev)
			driveAngle = wrapAngle(rotorAngle - bsc_pkg::QUARTER_TURN - int'(advance));
		else
			driveAngle = wrapAngle(rotorAngle + bsc_pkg::QUARTER_TURN + int'(advance));
	end

	logic [2:0] wantUpper;
	logic       blockAll;
	logic [2:0] upperOn;
	logic [2:0] lowerOn;

	assign blockAll = ~haltOk | overCurrent | hallBad;

	genvar ph;
	generate
		for (ph = 0; ph < 3; ph++)
		begin : gPhase
			logic [7:0] phAngle;
			assign phAngle       = wrapAngle(int'(driveAngle) + ph * bsc_pkg::PHASE_SHIFT);
			assign wantUpper[ph] = sineLevel(phAngle, amplitude) > carrierQ;

			bsc_dead_band uDead
			(
				.clk        (clk),
				.rst_b      (rst_b),
				.wantUpper  (wantUpper[ph]),
				.block      (blockAll),
				.deadCycles (deadCycles),
				.upperOn    (upperOn[ph]),
				.lowerOn    (lowerOn[ph])
			);
		end
	endgenerate

	// ************************************************
	// Output stage
	// ************************************************
	// polarity applied last; blocking repeated here so a block is one cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			phaseUpper <= bsc_pkg::PHASE_OFF_RESET;
			phaseLower <= bsc_pkg::PHASE_OFF_RESET;
			blockQ     <= 1'b1;
		end
		else
		begin
			blockQ     <= blockAll;
			phaseUpper <= polHigh ? (upperOn & {3{~blockAll}}) : ~(upperOn & {3{~blockAll}});
			phaseLower <= polHigh ? (lowerOn & {3{~blockAll}}) : ~(lowerOn & {3{~blockAll}});
		end
	end

	// xor of three halls toggles six times per turn
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			speedPulseOutput <= 1'b0;
		else
			speedPulseOutput <= ^hall;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			backwardSpinFlag <= 1'b0;
			backQ            <= 1'b0;
		end
		else
		begin
			backwardSpinFlag <= haltOk & (measRevQ != dirRev);
			backQ            <= haltOk & (measRevQ != dirRev);
		end
	end

endmodule // bsc_sine_pwm

// ### testbench/bsc_sine_pwm_chk.sv
// Port-level checker for the sine-PWM controller
`timescale 1ns/1ps
module bsc_sine_pwm_chk
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rotorPosition1,
	input wire logic        rotorPosition2,
	input wire logic        rotorPosition3,
	input wire logic        haltInput_n,
	input wire logic        overcurrentSense,
	input wire logic [2:0]  phaseUpper,
	input wire logic [2:0]  phaseLower,
	input wire logic        speedPulseOutput,
	input wire logic        backwardSpinFlag
);
	logic [2:0] polHist_q;
	logic [1:0] age_q;
	logic [9:0] idle_q;
	logic [2:0] ina;
	logic       live;
	logic       offU;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Judge outputs only once reset and polarity have settled
	assign ina  = {3{~polHist_q[0]}};
	assign live = age_q == 2'h3 && (polHist_q == 3'h0 || polHist_q == 3'h7);
	assign offU = phaseUpper[0] == ina[0] && phaseLower[0] == ina[0];
	// Polarity mirrored from bus writes, the register itself is hidden
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			polHist_q <= 3'h0;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			polHist_q <= {polHist_q[1:0], pwdata[bsc_pkg::CTRL_POL_BIT]};
		else
			polHist_q <= {polHist_q[1:0], polHist_q[0]};
	// Cycles since reset release, saturating
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			age_q <= 2'h0;
		else if (age_q != 2'h3)
			age_q <= age_q + 2'h1;
	// Idle run length of the first phase pair
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			idle_q <= 10'h0;
		else if (!offU)
			idle_q <= 10'h0;
		else if (idle_q != 10'h3ff)
			idle_q <= idle_q + 10'h1;
	sequence sHallSame;
		(rotorPosition1 == rotorPosition2 && rotorPosition2 == rotorPosition3)[*6];
	endsequence
	sequence sAllOff;
		phaseUpper == ina && phaseLower == ina;
	endsequence
	a_hall_block: assert property (sHallSame ##0 live |-> sAllOff)
		else $error("equal rotor code left outputs on");
	a_halt_block: assert property ((!haltInput_n)[*6] ##0 live |-> sAllOff)
		else $error("halt left outputs on");
	a_ovc_block: assert property (overcurrentSense[*6] ##0 live |-> sAllOff)
		else $error("overcurrent left outputs on");
	a_pair_exclusive: assert property (live |-> ((phaseUpper ^ ina) & (phaseLower ^ ina)) == 3'h0)
		else $error("both switches of a phase on");
	a_dead_gap: assert property (live && idle_q != 10'h0 && !offU |-> idle_q >= bsc_pkg::DEAD_SHORT_CYC - 10'h1)
		else $error("dead interval too short");
	a_pulse_xor: assert property (($stable({rotorPosition1, rotorPosition2, rotorPosition3}) && haltInput_n)[*5] ##0 live
		|-> speedPulseOutput == (rotorPosition1 ^ rotorPosition2 ^ rotorPosition3))
		else $error("speed pulse does not follow rotor code");
	a_halt_noback: assert property ((!haltInput_n)[*6] |-> !backwardSpinFlag)
		else $error("backward flag while halted");
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_err_map: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
		else $error("slave error does not match address");
endmodule // bsc_sine_pwm_chk

bind bsc_sine_pwm bsc_sine_pwm_chk u_chk
(
	.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
	.rotorPosition1, .rotorPosition2, .rotorPosition3, .haltInput_n, .overcurrentSense,
	.phaseUpper, .phaseLower, .speedPulseOutput, .backwardSpinFlag
);

// ### testbench/bsc_motor_model.sv
// Rotor position sensors of the motor side
`timescale 1ns/1ps
module bsc_motor_model
(
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic        reverse,
	input  wire logic        holdEn,
	input  wire logic [2:0]  holdCode,
	input  wire logic [11:0] stepCycles,
	output logic      [2:0]  hall = 3'h5
);
	logic [2:0] seqTbl [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	int         idx = 0;
	int         cnt = 0;
	// forward order, stepped backward on request
	// held codes stand in for a broken sensor
	always @(posedge clk)
	begin
		if (run)
		begin
			cnt = cnt + 1;
			if (cnt >= stepCycles)
			begin
				cnt = 0;
				idx = reverse ? (idx + 5) % 6 : (idx + 1) % 6;
			end
		end
		hall <= holdEn ? holdCode : seqTbl[idx];
	end
endmodule // bsc_motor_model

// ### testbench/bsc_sine_pwm_tb.sv
// Self-checking bench for the sine-PWM brushless controller
`timescale 1ns/1ps
module bsc_sine_pwm_tb;
	typedef struct {logic [31:0] d; logic e; logic rd;} bsc_exp_t;
	logic        clk = 1'h0;
	logic        rst_b = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic        haltInput_n = 1'h0;
	logic        overcurrentSense = 1'h0;
	logic        run = 1'h0;
	logic        reverse = 1'h0;
	logic        holdEn = 1'h0;
	logic [2:0]  holdCode = 3'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  hall;
	logic [2:0]  phaseUpper;
	logic [2:0]  phaseLower;
	logic        speedPulseOutput;
	logic        backwardSpinFlag;
	logic [2:0]  ina = 3'h7;
	bsc_exp_t    expQ[$];
	bsc_exp_t    ex;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          seed = 6056;

	bsc_sine_pwm #(.TIMER_W(12)) dut
	(
		.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.rotorPosition1(hall[2]), .rotorPosition2(hall[1]), .rotorPosition3(hall[0]),
		.haltInput_n, .overcurrentSense, .phaseUpper, .phaseLower, .speedPulseOutput, .backwardSpinFlag
	);
	bsc_motor_model model
	(
		.clk, .run, .reverse, .holdEn, .holdCode, .stepCycles(12'h12c), .hall
	);

	// Free-running 200 MHz clock
	initial forever #2.5 clk = ~clk;

	task automatic stop_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'h1)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// One bus transfer, left standing so a setup may follow at once
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] ed, input logic ee);
		int n;
		n = 0;
		expQ.push_back('{ed, ee, ~w});
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		penable <= 1'h0;
		@(posedge clk);
		penable <= 1'h1;
		// Request stands until pready is seen high at a rising edge
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1)
			check(1'h0, "bus answer missing");
	endtask

	task automatic idle(input int n);
		psel <= 1'h0;
		penable <= 1'h0;
		repeat (n) @(posedge clk);
	endtask

	// Bus answers compared with the oldest note, settled at the falling edge
	always @(negedge clk)
		if (psel && penable && pready === 1'h1)
		begin
			ex = expQ.pop_front();
			check(pslverr === ex.e && (!ex.rd || prdata === ex.d), "bus answer wrong");
		end

	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			check(1'h0, "run timed out");
			stop_test();
		end
	end

	initial
	begin
		logic [31:0] ctrl;
		logic        su;
		logic        sl;
		logic        p;
		int          dc;
		int          t;
		repeat (16) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		// Reset value, refused and read-only places
		apb(8'h00, 1'h0, 32'h0, bsc_pkg::CTRL_RESET, 1'h0);
		apb(8'h08, 1'h1, 32'hffff, 32'h0, 1'h1);
		apb(8'h0c, 1'h0, 32'h0, 32'h0, 1'h1);
		apb(8'h04, 1'h1, 32'hffff, 32'h0, 1'h0);
		apb(8'h00, 1'h0, 32'h0, bsc_pkg::CTRL_RESET, 1'h0);
		idle(1);
		$display("register test done");
		// Every polarity and dead select combination
		for (int k = 0; k < 4; k++)
		begin
			ctrl = {16'h0, 8'hff, 5'($random(seed)), k[1], k[0], 1'h0};
			haltInput_n <= 1'h0;
			apb(8'h00, 1'h1, ctrl, 32'h0, 1'h0);
			apb(8'h00, 1'h0, 32'h0, ctrl, 1'h0);
			idle(8);
			ina = {3{~k[0]}};
			check(phaseUpper === ina && phaseLower === ina, "halt leaves outputs on");
			run <= 1'h1;
			haltInput_n <= 1'h1;
			dc = (k[1] ? 2600 : 3800) * 200 / 1000;
			t = 0;
			while (phaseUpper === ina && phaseLower === ina && t < dc + 4000)
			begin
				@(negedge clk);
				t++;
			end
			check(t >= dc && t <= dc + 8, "dead interval wrong");
			su = 1'h0;
			sl = 1'h0;
			repeat (4000)
			begin
				@(negedge clk);
				su |= phaseUpper[0] !== ina[0];
				sl |= phaseLower[0] !== ina[0];
			end
			check(su && sl, "phase pair not both driven");
			@(posedge clk);
			for (int m = 0; m < 3; m++)
			begin
				holdEn <= m < 2;
				holdCode <= {3{m[0]}};
				overcurrentSense <= m == 2;
				idle(8);
				check(phaseUpper === ina && phaseLower === ina, "outputs not blocked");
				holdEn <= 1'h0;
				overcurrentSense <= 1'h0;
				idle(2);
			end
			$display("drive test %0d done", k);
		end
		// Commanded against measured direction, pulses per turn
		for (int d = 0; d < 4; d++)
		begin
			apb(8'h00, 1'h1, {16'h0, 8'hff, 7'h0, d[0]}, 32'h0, 1'h0);
			idle(1);
			reverse <= d[1];
			repeat (1800) @(posedge clk);
			t = 0;
			p = speedPulseOutput;
			repeat (1800)
			begin
				@(negedge clk);
				if (speedPulseOutput === 1'h1 && p === 1'h0)
					t++;
				p = speedPulseOutput;
			end
			check(t == 3, "speed pulse count wrong");
			check(backwardSpinFlag === (d[0] ^ d[1]), "backward flag wrong");
			@(posedge clk);
			$display("direction test %0d done", d);
		end
		// Reset again in mid-run
		rst_b <= 1'h0;
		idle(3);
		check(phaseUpper === 3'h7 && phaseLower === 3'h7 && pready === 1'h0, "reset outputs wrong");
		rst_b <= 1'h1;
		idle(1);
		apb(8'h00, 1'h0, 32'h0, bsc_pkg::CTRL_RESET, 1'h0);
		idle(1);
		$display("reset test done");
		stop_test();
	end
endmodule // bsc_sine_pwm_tb
